/* File: design/pas_cfg.svh */
// constants for the pwm auto-shutdown block: offsets, field positions, reset values
`ifndef PAS_CFG_SVH
`define PAS_CFG_SVH

// register byte offsets on apb
`define PAS_OFF_CCP_CTRL   8'h00
`define PAS_OFF_DUTY_HIGH  8'h04
`define PAS_OFF_ASD_CTRL   8'h08
`define PAS_OFF_TIMEBASE   8'h0c
`define PAS_OFF_IRQ_STAT   8'h10
`define PAS_OFF_IRQ_MASK   8'h14
`define PAS_OFF_LIVE_STAT  8'h18

// ccp control fields
`define PAS_CCP_CFG_HI     7
`define PAS_CCP_CFG_LO     6
`define PAS_CCP_DLO_HI     5
`define PAS_CCP_DLO_LO     4
`define PAS_CCP_POL_AC     1
`define PAS_CCP_POL_BD     0

// auto-shutdown control fields
`define PAS_ASD_FLAG       7
`define PAS_ASD_SRC_HI     6
`define PAS_ASD_SRC_LO     4
`define PAS_ASD_AC_HI      3
`define PAS_ASD_AC_LO      2
`define PAS_ASD_BD_HI      1
`define PAS_ASD_BD_LO      0

// timebase fields: period [7:0], steering [11:8], dead band [15:12]
`define PAS_TB_STEER_LO    8
`define PAS_TB_DB_LO       12

// interrupt status bits
`define PAS_IRQ_SHUT       0
`define PAS_IRQ_PERIOD     1

// reset values
`define PAS_RST_BYTE       8'h00
`define PAS_RST_TB         16'h0000
`define PAS_RST_IRQ        2'h0

`endif

/* File: design/pas_pkg.sv */
// types for the pwm auto-shutdown block
package pas_pkg;

  // shutdown sequencer, one-hot
  typedef enum logic [2:0] {
    PAS_RUN  = 3'b001,  // outputs modulate
    PAS_SHUT = 3'b010,  // flag set, outputs forced
    PAS_WAIT = 3'b100   // flag cleared, holding until next period
  } pas_state_t;

  // output configuration codes
  typedef enum logic [1:0] {
    PAS_CFG_SINGLE = 2'b00,
    PAS_CFG_FWD    = 2'b01,
    PAS_CFG_HALF   = 2'b10,
    PAS_CFG_REV    = 2'b11
  } pas_cfg_t;

  // pair shutdown state codes
  typedef enum logic [1:0] {
    PAS_SS_LOW  = 2'b00,
    PAS_SS_HIGH = 2'b01,
    PAS_SS_TRI  = 2'b10,
    PAS_SS_RSV  = 2'b11
  } pas_ss_t;

endpackage

/* File: design/pas_top.sv */
// pwm output stage with auto-shutdown, apb register slave and interrupt
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "pas_cfg.svh"

module pas_top
  import pas_pkg::*;
(
  input  wire logic        pclk,                  // system clock, 25 mhz
  input  wire logic        presetn,               // async reset, active low
  input  wire logic        psel,                  // apb select
  input  wire logic        penable,               // apb access phase
  input  wire logic        pwrite,                // apb direction
  input  wire logic [7:0]  paddr,                 // apb byte address
  input  wire logic [31:0] pwdata,                // apb write data
  output logic      [31:0] prdata,                // apb read data
  output logic             pready,                // apb ready
  output logic             pslverr,               // apb error, unmapped
  input  wire logic        ext_irq_zero_pin,      // shutdown pin, active low
  input  wire logic        comparator_one_output, // comparator one level
  input  wire logic        comparator_two_output, // comparator two level
  output logic             pwm_out_a,             // pwm pin a
  output logic             pwm_out_b,             // pwm pin b
  output logic             pwm_out_c,             // pwm pin c
  output logic             pwm_out_d,             // pwm pin d
  output logic             pwm_oe_n_a,            // pin a enable, low drives
  output logic             pwm_oe_n_b,            // pin b enable, low drives
  output logic             pwm_oe_n_c,            // pin c enable, low drives
  output logic             pwm_oe_n_d,            // pin d enable, low drives
  output logic             irq                    // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0]  ccp_r,  ccp_nxt;        // config, duty low bits, mode
  logic [7:0]  dhi_r,  dhi_nxt;        // duty high byte
  logic [7:0]  asd_r,  asd_nxt;        // auto-shutdown control
  logic [15:0] tb_r,   tb_nxt;         // period, steering, dead band
  logic [1:0]  ist_r,  ist_nxt;        // sticky interrupt status
  logic [1:0]  imsk_r, imsk_nxt;       // interrupt mask
  logic        irq_r,  irq_nxt;        // registered interrupt
  logic        rdy_r,  rdy_nxt;        // apb ready
  logic        err_r,  err_nxt;        // apb error
  logic [31:0] rd_r,   rd_nxt;         // apb read data
  pas_state_t  st_r,   st_nxt;         // shutdown sequencer
  logic [9:0]  cnt_r,  cnt_nxt;        // ten-bit time base
  logic        mod_d_r, mod_d_nxt;     // previous modulation level
  logic [3:0]  db_cnt_r, db_cnt_nxt;   // dead-band delay counter
  logic [3:0]  pwm_r,  pwm_nxt;        // registered drive {d,c,b,a}

  logic        acc_go;                 // access phase, first cycle
  logic        wr_done;                // write completes this edge
  logic        rd_done;                // read completes this edge
  logic        hit;                    // address is mapped
  logic        pwm_en;                 // pwm mode selected
  logic        ev;                     // live shutdown event
  logic        force_sd;               // outputs forced to safe state
  logic        period_end;             // last count of the period
  logic [9:0]  duty;                   // ten-bit duty value
  logic        mod;                    // raw modulation level
  logic        db_ok;                  // dead band elapsed
  logic [3:0]  act;                    // active levels before polarity
  logic [3:0]  pol;                    // per-pin active-low select
  logic [2:0]  src;                    // shutdown source select
  logic [1:0]  ss_ac;                  // a/c shutdown state
  logic [1:0]  ss_bd;                  // b/d shutdown state

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode

  // one wait state keeps prdata and pready both registered
  always_comb begin
    acc_go  = psel && penable && !rdy_r;
    wr_done = psel && penable && rdy_r && pwrite && !err_r;
    rd_done = psel && penable && rdy_r && !pwrite;
    unique case (paddr)
      `PAS_OFF_CCP_CTRL, `PAS_OFF_DUTY_HIGH, `PAS_OFF_ASD_CTRL, `PAS_OFF_TIMEBASE,
      `PAS_OFF_IRQ_STAT, `PAS_OFF_IRQ_MASK, `PAS_OFF_LIVE_STAT: hit = 1'b1;
      default: hit = 1'b0;                      // unmapped answers with error
    endcase
  end

  // field views
  always_comb begin
    pwm_en = (ccp_r[3:2] == 2'b11);
    src    = asd_r[`PAS_ASD_SRC_HI:`PAS_ASD_SRC_LO];
    ss_ac  = asd_r[`PAS_ASD_AC_HI:`PAS_ASD_AC_LO];
    ss_bd  = asd_r[`PAS_ASD_BD_HI:`PAS_ASD_BD_LO];
    duty   = {dhi_r, ccp_r[`PAS_CCP_DLO_HI:`PAS_CCP_DLO_LO]};
    pol    = {ccp_r[`PAS_CCP_POL_BD], ccp_r[`PAS_CCP_POL_AC],
              ccp_r[`PAS_CCP_POL_BD], ccp_r[`PAS_CCP_POL_AC]};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shutdown source decode

  // purely combinational so the pins react without a clock edge
  always_comb begin
    ev = (src[0] && comparator_one_output)
      || (src[1] && comparator_two_output)
      || (src[2] && !ext_irq_zero_pin);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers: next values

  always_comb begin
    ccp_nxt  = ccp_r;
    dhi_nxt  = dhi_r;
    asd_nxt  = asd_r;
    tb_nxt   = tb_r;
    imsk_nxt = imsk_r;
    ist_nxt  = ist_r;
    if (wr_done) begin
      unique case (paddr)
        `PAS_OFF_CCP_CTRL:  ccp_nxt  = pwdata[7:0];
        `PAS_OFF_DUTY_HIGH: dhi_nxt  = pwdata[7:0];
        `PAS_OFF_ASD_CTRL:  asd_nxt  = pwdata[7:0];     // firmware may clear the flag
        `PAS_OFF_TIMEBASE:  tb_nxt   = pwdata[15:0];
        `PAS_OFF_IRQ_MASK:  imsk_nxt = pwdata[1:0];
        default: ;                                      // read-only or unmapped
      endcase
    end
    // read of status clears it; a new event below still wins
    if (rd_done && paddr == `PAS_OFF_IRQ_STAT) begin
      // clear only what the read returned: a bit set during the access survives
      ist_nxt = ist_r & ~rd_r[1:0];
    end
    // event sets the flag and it wins over a clearing write
    if (ev && pwm_en) begin
      asd_nxt[`PAS_ASD_FLAG]  = 1'b1;
      ist_nxt[`PAS_IRQ_SHUT]  = 1'b1;
    end
    if (period_end) begin
      ist_nxt[`PAS_IRQ_PERIOD] = 1'b1;
    end
    irq_nxt = |(ist_nxt & imsk_nxt);
  end

  // apb answer
  always_comb begin
    rdy_nxt = acc_go;
    err_nxt = acc_go && !hit;
    rd_nxt  = 32'h0000_0000;
    if (acc_go && !pwrite) begin
      unique case (paddr)
        `PAS_OFF_CCP_CTRL:  rd_nxt[7:0]  = ccp_r;
        `PAS_OFF_DUTY_HIGH: rd_nxt[7:0]  = dhi_r;
        `PAS_OFF_ASD_CTRL:  rd_nxt[7:0]  = asd_r;
        `PAS_OFF_TIMEBASE:  rd_nxt[15:0] = tb_r;
        `PAS_OFF_IRQ_STAT:  rd_nxt[1:0]  = ist_r;
        `PAS_OFF_IRQ_MASK:  rd_nxt[1:0]  = imsk_r;
        `PAS_OFF_LIVE_STAT: rd_nxt[4:0]  = {force_sd, ev, comparator_two_output,
                                            comparator_one_output, ext_irq_zero_pin};
        default: ;                                      // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccp_r  <= `PAS_RST_BYTE;
      dhi_r  <= `PAS_RST_BYTE;
      asd_r  <= `PAS_RST_BYTE;
      tb_r   <= `PAS_RST_TB;
      ist_r  <= `PAS_RST_IRQ;
      imsk_r <= `PAS_RST_IRQ;
      irq_r  <= 1'b0;
      rdy_r  <= 1'b0;
      err_r  <= 1'b0;
      rd_r   <= 32'h0000_0000;
    end else begin
      ccp_r  <= ccp_nxt;
      dhi_r  <= dhi_nxt;
      asd_r  <= asd_nxt;
      tb_r   <= tb_nxt;
      ist_r  <= ist_nxt;
      imsk_r <= imsk_nxt;
      irq_r  <= irq_nxt;
      rdy_r  <= rdy_nxt;
      err_r  <= err_nxt;
      rd_r   <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shutdown sequencer

  // holds the pins after the flag clears until the period restarts
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      PAS_RUN:  if (asd_nxt[`PAS_ASD_FLAG]) st_nxt = PAS_SHUT;
      PAS_SHUT: if (!asd_nxt[`PAS_ASD_FLAG]) st_nxt = PAS_WAIT;
      PAS_WAIT: begin
        if (asd_nxt[`PAS_ASD_FLAG]) st_nxt = PAS_SHUT;
        else if (period_end || !pwm_en) st_nxt = PAS_RUN;
      end
      default: st_nxt = PAS_SHUT;                       // illegal code: stay safe
    endcase
    force_sd = pwm_en && (ev || st_r != PAS_RUN);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_r <= PAS_RUN;
    else          st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // time base, duty compare, dead band

  always_comb begin
    period_end = pwm_en && (cnt_r == {tb_r[7:0], 2'b11});
    cnt_nxt    = (!pwm_en || period_end) ? 10'h000 : cnt_r + 10'h001;
    mod        = pwm_en && (cnt_r < duty);
    mod_d_nxt  = mod;
    if (mod != mod_d_r) db_cnt_nxt = 4'h0;
    else if (db_cnt_r == tb_r[15:12]) db_cnt_nxt = db_cnt_r;
    else db_cnt_nxt = db_cnt_r + 4'h1;
    // edge cycle only passes when no dead band is programmed
    db_ok = (mod == mod_d_r) ? (db_cnt_r >= tb_r[15:12]) : (tb_r[15:12] == 4'h0);
  end

  // drive pattern per configuration, bits {d,c,b,a}
  always_comb begin
    act = 4'h0;
    unique case (pas_cfg_t'(ccp_r[`PAS_CCP_CFG_HI:`PAS_CCP_CFG_LO]))
      PAS_CFG_SINGLE: act = tb_r[11:8] & {4{mod}};
      PAS_CFG_FWD:    act = {mod, 1'b0, 1'b0, 1'b1};
      PAS_CFG_HALF:   act = {2'b00, !mod && db_ok, mod && db_ok};
      PAS_CFG_REV:    act = {1'b0, 1'b1, mod, 1'b0};
    endcase
    pwm_nxt = pwm_en ? (act ^ pol) : 4'h0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r    <= 10'h000;
      mod_d_r  <= 1'b0;
      db_cnt_r <= 4'h0;
      pwm_r    <= 4'h0;
    end else begin
      cnt_r    <= cnt_nxt;
      mod_d_r  <= mod_d_nxt;
      db_cnt_r <= db_cnt_nxt;
      pwm_r    <= pwm_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin override

  // the force path bypasses the flops on purpose: a clocked path
  // would leave the bridge on for up to a cycle after a fault
  always_comb begin
    pwm_out_a  = force_sd ? (ss_ac == PAS_SS_HIGH) : pwm_r[0];
    pwm_out_c  = force_sd ? (ss_ac == PAS_SS_HIGH) : pwm_r[2];
    pwm_out_b  = force_sd ? (ss_bd == PAS_SS_HIGH) : pwm_r[1];
    pwm_out_d  = force_sd ? (ss_bd == PAS_SS_HIGH) : pwm_r[3];
    pwm_oe_n_a = force_sd && (ss_ac == PAS_SS_TRI);
    pwm_oe_n_c = force_sd && (ss_ac == PAS_SS_TRI);
    pwm_oe_n_b = force_sd && (ss_bd == PAS_SS_TRI);
    pwm_oe_n_d = force_sd && (ss_bd == PAS_SS_TRI);
    prdata     = rd_r;
    pready     = rdy_r;
    pslverr    = err_r;
    irq        = irq_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_flag_cleared;
    $fell(asd_r[`PAS_ASD_FLAG]) ##0 !ev;
  endsequence
  sequence s_read_asd;
    psel && penable && !rdy_r && !pwrite && paddr == `PAS_OFF_ASD_CTRL;
  endsequence

  property p_src_off;
    (src == 3'b000) |-> !ev;
  endproperty
  a_src_off: assert property (p_src_off) else $error("event with sources off");

  property p_pin_low;
    (src[2] && !ext_irq_zero_pin) |-> ev;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin low missed");

  property p_flag_set;
    (ev && pwm_en) |=> asd_r[`PAS_ASD_FLAG] && st_r == PAS_SHUT;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_force_now;
    (ev && pwm_en && ss_ac == PAS_SS_LOW) |-> !pwm_out_a && !pwm_out_c && !pwm_oe_n_a;
  endproperty
  a_force_now: assert property (p_force_now) else $error("a/c not forced low");

  property p_bd_high;
    (force_sd && ss_bd == PAS_SS_HIGH) |-> pwm_out_b && pwm_out_d && !pwm_oe_n_d;
  endproperty
  a_bd_high: assert property (p_bd_high) else $error("b/d not high");

  property p_ac_tri;
    (force_sd && ss_ac == PAS_SS_TRI) |-> pwm_oe_n_a && pwm_oe_n_c;
  endproperty
  a_ac_tri: assert property (p_ac_tri) else $error("a/c not released");

  property p_flag_shows;
    s_read_asd |=> pready && prdata[7] == $past(asd_r[`PAS_ASD_FLAG]);
  endproperty
  a_flag_shows: assert property (p_flag_shows) else $error("flag read wrong");

  // the cycle the flag drops, the pins must still show the safe state
  property p_hold_period;
    s_flag_cleared ##0 pwm_en |-> force_sd && pwm_out_b == (ss_bd == PAS_SS_HIGH);
  endproperty
  a_hold_period: assert property (p_hold_period) else $error("resumed early");

  property p_fwd_pattern;
    (pwm_en && ccp_r[7:6] == 2'b01) |=> pwm_r[0] == !$past(ccp_r[1])
                                        && pwm_r[1] == $past(ccp_r[0]);
  endproperty
  a_fwd_pattern: assert property (p_fwd_pattern) else $error("forward pattern wrong");

  property p_duty;
    (pwm_en && ccp_r[7:6] == 2'b00 && tb_r[8] && cnt_r < duty) |=> pwm_r[0] != $past(ccp_r[1]);
  endproperty
  a_duty: assert property (p_duty) else $error("duty compare wrong");

endmodule // pas_top

`default_nettype wire

/* File: tb/pas_bridge_model.sv */
// far-side model: bridge driver pads, comparators and shutdown pin
`timescale 1ns/10ps
`default_nettype none

module pas_bridge_model (
  input  wire logic       pclk,    // system clock
  input  wire logic       presetn, // async reset, active low
  input  wire logic [2:0] fault,   // raise {pin, c2, c1} fault
  input  wire logic [3:0] out,     // pin levels {a,b,c,d}
  input  wire logic [3:0] oe_n,    // pin enables, low drives
  output logic            pin_n,   // shutdown pin, active low
  output logic            cmp1,    // comparator one level
  output logic            cmp2,    // comparator two level
  output logic [3:0]      pad      // levels the bridge sees
);
  logic [3:0] last_r; // last pad level

  // fault sources: pin pulled low, comparators go high
  assign pin_n = ~fault[2];
  assign cmp1  = fault[0];
  assign cmp2  = fault[1];

  // no pull on the pads, so a released pad must not hold a stale level
  assign pad = (out & ~oe_n) | (~last_r & oe_n);

  // remember each pad level, released pads then flip every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_r <= 4'h0;
    end else begin
      last_r <= pad;
    end
  end
endmodule // pas_bridge_model

`default_nettype wire

/* File: tb/pas_top_test.sv */
// self-checking bench for the pwm auto-shutdown block
`timescale 1ns/10ps
`default_nettype none

module pas_top_test import pas_pkg::*; ;
  typedef struct packed {
    logic [31:0] d; // expected data
    logic [31:0] m; // bits compared
    logic        e; // expected error
  } pas_note_t;

  logic        pclk, presetn, psel, penable, pwrite; // apb master side
  logic [7:0]  paddr;                                // byte address
  logic [31:0] pwdata, prdata;                       // data buses
  logic        pready, pslverr, irq;                 // slave answers
  logic        pin_n, cmp1, cmp2;                    // shutdown sources
  logic        pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d;
  logic        pwm_oe_n_a, pwm_oe_n_b, pwm_oe_n_c, pwm_oe_n_d;
  logic [2:0]  fault;                                // model fault command
  logic [3:0]  pad;                                  // pads seen by bridge
  integer      fails, checked;                       // counters
  int          seed;                                 // random seed
  pas_note_t   notes[$];                             // pending transfer notes
  pas_note_t   got;                                  // note under compare
  logic [7:0]  mode_tab[7] = '{8'h4c, 8'hcc, 8'h4f, 8'hcf, 8'h7c, 8'h3c, 8'hbe}; // ctrl
  logic [3:0]  pins_tab[7] = '{4'h8, 4'h2, 4'h7, 4'hd, 4'h9, 4'ha, 4'h2};       // {a,b,c,d}

  pas_top u_pas_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_zero_pin(pin_n), .comparator_one_output(cmp1),
    .comparator_two_output(cmp2), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
    .pwm_out_c(pwm_out_c), .pwm_out_d(pwm_out_d), .pwm_oe_n_a(pwm_oe_n_a),
    .pwm_oe_n_b(pwm_oe_n_b), .pwm_oe_n_c(pwm_oe_n_c), .pwm_oe_n_d(pwm_oe_n_d),
    .irq(irq));

  pas_bridge_model u_pas_bridge_model (.pclk(pclk), .presetn(presetn), .fault(fault),
    .out({pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d}),
    .oe_n({pwm_oe_n_a, pwm_oe_n_b, pwm_oe_n_c, pwm_oe_n_d}),
    .pin_n(pin_n), .cmp1(cmp1), .cmp2(cmp2), .pad(pad));

  ////////////////////////////////////////////////////////////////////////////////
  // clock, 40 ns period
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one apb transfer; for reads d is the expected data
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    notes.push_back('{d: d, m: (w ? 32'h0 : m), e: e});
    @(posedge pclk);
    penable <= 1'b1;
    // pready is sampled at each rising edge; the request stands until then
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      $display("ERROR %0t apb answer never came", $time);
      summarize();
    end
    // release at the edge that sampled pready high
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // masked compare of a 4-bit value
  task automatic chk(input logic [3:0] g, input logic [3:0] e, input logic [3:0] m);
    checked++;
    if (((g ^ e) & m) !== 4'h0) begin
      fails++;
      $display("ERROR %0t got %b expected %b", $time, g, e);
    end
  endtask

  // pad levels where driven, and all enables
  task automatic pins(input logic [3:0] eo, input logic [3:0] en);
    @(negedge pclk);
    chk(pad, eo, ~en);
    chk({pwm_oe_n_a, pwm_oe_n_b, pwm_oe_n_c, pwm_oe_n_d}, en, 4'hf);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watcher: each completed transfer takes the oldest note at the sampling edge
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      got = notes.pop_front();
      checked++;
      if ((((prdata ^ got.d) & got.m) !== 32'h0) || (pslverr !== got.e)) begin
        fails++;
        $display("ERROR %0t addr %h data %h err %b", $time, paddr, prdata, pslverr);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] r;
    logic [2:0]  sv;
    logic [1:0]  ac, bd;
    logic        en, msk;
    {psel, penable, pwrite, paddr, pwdata, fault} = '0;
    presetn = 1'b0;
    fails   = 0;
    checked = 0;
    seed    = 32'h0d7aba33;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values; pwm is off so no period status yet, pin idles high
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), (i == 6) ? 32'h1 : 32'h0, '1, 1'b0);
    end
    apb(1'b0, 8'h1c, 32'h0, '1, 1'b1);
    apb(1'b1, 8'h18, 32'h1f, '1, 1'b0);
    apb(1'b0, 8'h18, 32'h1, '1, 1'b0);
    r = 32'($random(seed)) & 32'h7f;
    apb(1'b1, 8'h08, r, '1, 1'b0);
    apb(1'b0, 8'h08, r, '1, 1'b0);
    $display("test registers done");
    // drive patterns and polarity: eight counts, steering a and c, dead band three
    apb(1'b1, 8'h0c, 32'h3501, '1, 1'b0);
    for (int j = 0; j < 7; j++) begin
      if (j == 4) begin
        apb(1'b1, 8'h04, 32'hff, '1, 1'b0);
      end
      apb(1'b1, 8'h00, {24'h0, mode_tab[j]}, '1, 1'b0);
      repeat (10) @(posedge pclk);
      pins(pins_tab[j], 4'h0);
    end
    // period end has set its status bit, no shutdown seen
    apb(1'b0, 8'h10, 32'h2, '1, 1'b0);
    apb(1'b1, 8'h04, 32'h0, '1, 1'b0);
    apb(1'b1, 8'h00, 32'h4c, '1, 1'b0);
    $display("test patterns done");
    // every source code against every source
    for (int s = 0; s < 8; s++) begin
      for (int k = 0; k < 3; k++) begin
        sv  = 3'(s);
        ac  = 2'(s % 3);
        bd  = 2'($unsigned($random(seed)) % 3);
        en  = sv[k];
        msk = (k != 2);
        apb(1'b1, 8'h14, {31'h0, msk}, '1, 1'b0);
        apb(1'b1, 8'h08, {24'h0, 1'b0, sv, ac, bd}, '1, 1'b0);
        @(posedge pclk);
        fault <= 3'(1 << k);
        if (en) begin
          pins({ac == PAS_SS_HIGH, bd == PAS_SS_HIGH, ac == PAS_SS_HIGH, bd == PAS_SS_HIGH},
               {ac == PAS_SS_TRI, bd == PAS_SS_TRI, ac == PAS_SS_TRI, bd == PAS_SS_TRI});
        end else begin
          pins(4'h8, 4'h0);
        end
        apb(1'b0, 8'h08, {24'h0, en, sv, ac, bd}, '1, 1'b0);
        if (s == 4 && k == 2) begin
          apb(1'b0, 8'h18, 32'h18, '1, 1'b0);
        end
        @(negedge pclk);
        chk({3'h0, irq}, {3'h0, en & msk}, 4'h1);
        @(posedge pclk);
        fault <= 3'h0;
        apb(1'b1, 8'h08, {24'h0, 1'b0, sv, ac, bd}, '1, 1'b0);
        apb(1'b0, 8'h10, {31'h0, en}, 32'h1, 1'b0);
        repeat (10) @(posedge pclk);
        pins(4'h8, 4'h0);
        chk({3'h0, irq}, 4'h0, 4'h1);
        apb(1'b0, 8'h08, {24'h0, 1'b0, sv, ac, bd}, '1, 1'b0);
      end
    end
    $display("test shutdown done");
    summarize();
  end
endmodule // pas_top_test

`default_nettype wire
